// File: verilog/asop_defines.svh
// What this block does
// - Pipeline advances on rising clock edge only
// - Sample word is unsigned straight binary
// - Word and flag registered, held until next edge
// - Output control high puts outputs in high impedance
// - Overrange flag set above full scale
// - Overrange forces all code bits to one
// - Bit zero least significant, three-state outputs
// - Twelve cycle latency, one sample per clock
`ifndef ASOP_DEFINES_SVH
`define ASOP_DEFINES_SVH
`define ASOP_CODE_W 10
`define ASOP_LATENCY 12
`define ASOP_FIFO_DEPTH 8
`define ASOP_FIFO_AW 3
`define ASOP_CODE_MAX 10'h3FF
`define ASOP_CODE_ZERO 10'h000
`define ASOP_CAL_CYCLES 10000
`endif

// File: verilog/asop_pkg.sv
`include "asop_defines.svh"
package asop_pkg;
   typedef logic [`ASOP_CODE_W-1:0] asop_code_t;
endpackage

// File: verilog/asop_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module asop_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign in_ready = (cnt_ff != DEPTH[AW:0]);
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem[rd_ff];

   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
      nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
      nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ff] <= in_data;
      end
   end
endmodule // asop_fifo
`default_nettype wire

// File: verilog/asop_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "asop_defines.svh"
module asop_port (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire asop_pkg::asop_code_t conv_code,
   input wire logic conv_over,
   input wire logic out_ctl,
   output logic [`ASOP_CODE_W-1:0] sample_code_o,
   output logic [`ASOP_CODE_W-1:0] sample_code_oe,
   output logic overrange_flag_o,
   output logic overrange_flag_oe,
   output logic word_valid,
   output logic fifo_full
);
   import asop_pkg::*;
   localparam int W = `ASOP_CODE_W + 1;
   localparam int L = `ASOP_LATENCY - 1;

   // Conversion pipeline: one stage per clock, rising edge only
   logic [W-1:0] pipe_ff [L];
   logic [W-1:0] nxt_pipe [L];
   logic [W-1:0] head_data;
   logic head_valid, fifo_ready, fifo_valid;
   logic [W-1:0] fifo_data;
   logic [L-1:0] vld_ff, nxt_vld;
   logic [W-1:0] word_ff, nxt_word;
   logic wv_ff, nxt_wv;
   logic [2:0] oc_sync_ff;
   logic [2:0] nxt_oc_sync;
   logic oc_ff, nxt_oc;

   always_comb begin
      nxt_pipe[0] = {conv_over, conv_code};
      for (int i = 1; i < L; i++) begin
         nxt_pipe[i] = pipe_ff[i-1];
      end
      nxt_vld = {vld_ff[L-2:0], 1'b1};
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < L; i++) begin
            pipe_ff[i] <= '0;
         end
         vld_ff <= '0;
      end else begin
         for (int i = 0; i < L; i++) begin
            pipe_ff[i] <= nxt_pipe[i];
         end
         vld_ff <= nxt_vld;
      end
   end

   assign head_data = pipe_ff[L-1];
   assign head_valid = vld_ff[L-1];
   assign fifo_full = !fifo_ready;

   // Buffer in front of the output register; the output always drains it
   asop_fifo #(
      .WIDTH(W),
      .DEPTH(`ASOP_FIFO_DEPTH),
      .AW(`ASOP_FIFO_AW)
   ) u_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(head_valid),
      .in_ready(fifo_ready),
      .in_data(head_data),
      .out_valid(fifo_valid),
      .out_ready(1'b1),
      .out_data(fifo_data)
   );

   always_comb begin
      nxt_word = word_ff;
      nxt_wv = fifo_valid;
      if (fifo_valid) begin
         nxt_word[`ASOP_CODE_W] = fifo_data[`ASOP_CODE_W];
         if (fifo_data[`ASOP_CODE_W]) begin
            nxt_word[`ASOP_CODE_W-1:0] = `ASOP_CODE_MAX;
         end else begin
            nxt_word[`ASOP_CODE_W-1:0] = fifo_data[`ASOP_CODE_W-1:0];
         end
      end
      nxt_oc_sync = {oc_sync_ff[1:0], out_ctl};
      nxt_oc = (oc_sync_ff[2] == oc_sync_ff[1]) ? oc_sync_ff[2] : oc_ff;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         word_ff <= '0;
         wv_ff <= 1'b0;
         oc_sync_ff <= 3'h7;
         oc_ff <= 1'b1;
      end else begin
         word_ff <= nxt_word;
         wv_ff <= nxt_wv;
         oc_sync_ff <= nxt_oc_sync;
         oc_ff <= nxt_oc;
      end
   end

   assign sample_code_o = word_ff[`ASOP_CODE_W-1:0];
   assign overrange_flag_o = word_ff[`ASOP_CODE_W];
   assign sample_code_oe = {`ASOP_CODE_W{!oc_ff}};
   assign overrange_flag_oe = !oc_ff;
   assign word_valid = wv_ff;
endmodule // asop_port
`default_nettype wire

// File: bench/asop_chk.sv
`timescale 1ns/10ps
`default_nettype none
module asop_chk import asop_pkg::*; (input wire logic core_clk, rst_n,
   conv_over, out_ctl, overrange_flag_o, overrange_flag_oe, word_valid,
   fifo_full, input wire asop_code_t conv_code, sample_code_o,
   sample_code_oe);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_sat; overrange_flag_o |-> &sample_code_o; endproperty
   a_sat: assert property (p_sat) else $error("sat");
   property p_lat; word_valid && !$past(conv_over, 13) |->
      sample_code_o == $past(conv_code, 13); endproperty
   a_lat: assert property (p_lat) else $error("lat");
   property p_ovr; word_valid |-> overrange_flag_o == $past(conv_over, 13);
   endproperty
   a_ovr: assert property (p_ovr) else $error("ovr");
   property p_val; word_valid |=> word_valid; endproperty
   a_val: assert property (p_val) else $error("val");
   property p_off; out_ctl [*7] |-> !overrange_flag_oe; endproperty
   a_off: assert property (p_off) else $error("off");
   property p_on; (!out_ctl) [*7] |-> overrange_flag_oe; endproperty
   a_on: assert property (p_on) else $error("on");
   property p_oeq; sample_code_oe == {10{overrange_flag_oe}}; endproperty
   a_oeq: assert property (p_oeq) else $error("oeq");
   property p_full; !fifo_full; endproperty
   a_full: assert property (p_full) else $error("full");
   cover property (overrange_flag_o);
   cover property (out_ctl [*7]);
   cover property (word_valid [*8]);
endmodule // asop_chk
bind asop_port asop_chk u_chk (.*);
`default_nettype wire

// File: bench/asop_cap_model.sv
`timescale 1ns/10ps
`default_nettype none
module asop_cap_model import asop_pkg::*; (input wire logic core_clk,
   rst_n, word_valid, overrange_flag_o, overrange_flag_oe,
   input wire asop_code_t sample_code_o, output logic cap_new, cap_drv,
   output logic [10:0] cap_word);
   // Released pins read as the inverse of the previous cycle's cap_word, so they toggle each cycle
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n) {cap_new, cap_drv, cap_word} <= '0;
      else {cap_new, cap_drv, cap_word} <= {word_valid, overrange_flag_oe,
         overrange_flag_oe ? {overrange_flag_o, sample_code_o} : ~cap_word};
endmodule // asop_cap_model
`default_nettype wire

// File: bench/asop_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module asop_port_tb_top;
   import asop_pkg::*;
   logic core_clk = 0, rst_n = 0, conv_over = 0, out_ctl = 0, cap_new;
   logic overrange_flag_o, overrange_flag_oe, word_valid, fifo_full, cap_drv;
   asop_code_t conv_code = '0, sample_code_o, sample_code_oe;
   logic [10:0] cap_word, exp_q[$];
   int bad_count, n_tests, cyc, seed = 32'hBBBE;
   asop_port dut (.*);
   asop_cap_model cap (.*);
   initial forever #25 core_clk = ~core_clk;
   function automatic logic [10:0] want(asop_code_t c, logic o);
      return o ? 11'h7FF : {1'b0, c};
   endfunction
   task chk(logic [10:0] x, g, logic d);
      if (d === 1'b1) n_tests++;
      if (d === 1'b1 && g !== x) begin
         bad_count++;
         $display("unexpected word exp %h got %h", x, g);
      end
   endtask
   task summarize;
      bad_count += cyc > 2000;
      $display("bad_count %0d n_tests %0d", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc > 2000) summarize;
   end
   always @(posedge core_clk) begin
      if (!rst_n) exp_q = {};
      else exp_q.push_back(want(conv_code, conv_over));
      if (cap_new === 1'b1) chk(exp_q.pop_front(), cap_word, cap_drv);
   end
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1;
      for (int i = 0; i < 900; i++) begin
         @(posedge core_clk);
         conv_code <= i < 4 ? {10{i[0]}} : 10'($random(seed));
         conv_over <= i < 4 ? i[1] : $random(seed) % 5 == 0;
         out_ctl <= i inside {[300:309]};
         rst_n <= i != 600;
      end
      summarize;
   end
endmodule // asop_port_tb_top
`default_nettype wire
